// ==== rtl/ds2rx_status_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - nonzero sim code raises errors, traffic untouched
// - code 1: two framing-bit errors per multiframe
// - code 2: two m-bit or one parity error
// - codes 3-6: far alarm, red, ais, loop
// - copy bit copies counters, manual mode only
// - copy-clear bit copies then clears, manual only
// - commands self-clear before next access
// - mask bit high suppresses vector, resets 003f
// - mask bits: loop, ais, red, spare, far, fas
// - flags show condition; changes make vectors, except alignment moved
// - status 0001 at reset, then 0011
// - ais valid when under five zeros
// - ais up/down integrator per multiframe, or per half ms tick when timer param bit 6 is set
// - red up/down integrator on lost alignment
// - spare bit after 8 multiframes, aligned only
// - far alarm after 8 multiframes, aligned only
// - alignment moved flag on new differing position
// - status bit 0 shows out of frame
// - one loop detect bit per tributary
// - loop change reported after 5 multiframes
// - auto mode copies and clears each second
// - selector picks first, second or third c-bit
module ds2rx_status_ctrl
  import ds2rx_pkg::*;
#(
  parameter int unsigned HALF_MS_CYC = HALF_MS_CYCLES,
  parameter int unsigned ONE_SEC_CYC = ONE_SEC_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output var  logic [15:0] reg_rdata,
  output var  logic        reg_rvalid,
  input  wire logic [2:0]  group_select,
  input  wire logic        counter_transfer_mode,
  input  wire logic        e1_mode,
  input  wire logic [1:0]  loop_cbit_select,
  input  wire logic [7:0]  alarm_timer_params,
  input  wire logic        mf_end,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  input  wire logic        signal_present,
  input  wire logic        framer_oof,
  input  wire logic        align_found,
  input  wire logic        align_differs,
  input  wire logic        spare_bit,
  input  wire logic        far_bit_ds1,
  input  wire logic        far_bit_e1,
  input  wire logic [11:0] rx_cbits,
  output var  logic        cnt_copy,
  output var  logic        cnt_clear,
  output var  logic        sim_fbit_err,
  output var  logic        sim_mbit_err,
  output var  logic        sim_parity_err,
  output var  logic        irq_vec_valid,
  output var  logic [5:0]  irq_vec_source,
  output var  logic [2:0]  irq_vec_group
);

  logic [2:0]  sim_code_q;
  logic [5:0]  mask_q;
  logic [31:0] half_cnt_q;
  logic [31:0] sec_cnt_q;
  logic        half_tick;
  logic        sec_tick;
  logic [2:0]  zero_cnt_q;
  logic        ais_cond_q;
  logic [5:0]  ais_cnt_q;
  logic        ais_q;
  logic [5:0]  red_cnt_q;
  logic        red_q;
  logic        red_cond;
  logic        alarm_tick;
  logic        spare_q;
  logic        far_q;
  logic        far_src;
  logic        alignment_moved_flag_q;
  logic        oof_q;
  logic        sim_second_q;
  logic [3:0]  loop_q;
  logic [5:0]  flags;
  logic [5:0]  flags_prev_q;
  logic [3:0]  loop_prev_q;
  logic [5:0]  change;
  logic        cmd_wr;
  logic        copy_req;
  logic        clear_req;
  logic [15:0] status_word;

  assign cmd_wr     = reg_wr && reg_addr == ADDR_COMMAND;
  // manual commands only count while the counters are not in auto mode
  assign copy_req   = (cmd_wr && !counter_transfer_mode &&
                       (reg_wdata[COPY_BIT] || reg_wdata[COPY_CLR_BIT]))
                      || (counter_transfer_mode && sec_tick);
  assign clear_req  = (cmd_wr && !counter_transfer_mode &&
                       reg_wdata[COPY_CLR_BIT])
                      || (counter_transfer_mode && sec_tick);
  assign half_tick  = half_cnt_q == 32'(HALF_MS_CYC - 1);
  assign sec_tick   = sec_cnt_q == 32'(ONE_SEC_CYC - 1);
  assign alarm_tick = alarm_timer_params[6] ? half_tick : mf_end;
  assign red_cond   = framer_oof || sim_code_q == SIM_RED;
  assign far_src    = (sim_code_q == SIM_FAR) ||
                      (e1_mode ? far_bit_e1 : far_bit_ds1);
  assign status_word = {10'h000, ais_q, red_q, spare_q, far_q,
                        alignment_moved_flag_q, oof_q};

  // command and mask registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sim_code_q <= COMMAND_RESET[SIM_MSB:SIM_LSB];
      mask_q     <= MASK_RESET[5:0];
    end
    else if (ce && reg_wr)
    begin
      // status and loop addresses fall through untouched
      if (reg_addr == ADDR_COMMAND)
        sim_code_q <= reg_wdata[SIM_MSB:SIM_LSB];
      if (reg_addr == ADDR_MASK)
        mask_q <= reg_wdata[5:0];
    end
  end

  // counter transfer pulses last one cycle, done before the next access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_copy  <= 1'b0;
      cnt_clear <= 1'b0;
    end
    else if (ce)
    begin
      cnt_copy  <= copy_req;
      cnt_clear <= clear_req;
    end
  end

  // free running half millisecond and one second timebases
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_cnt_q <= 32'h0;
      sec_cnt_q  <= 32'h0;
    end
    else if (ce)
    begin
      half_cnt_q <= half_tick ? 32'h0 : half_cnt_q + 32'h1;
      sec_cnt_q  <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
    end
  end

  // simulated error pulses go to the error counters, not the data path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sim_fbit_err   <= 1'b0;
      sim_mbit_err   <= 1'b0;
      sim_parity_err <= 1'b0;
      sim_second_q   <= 1'b0;
    end
    else if (ce)
    begin
      sim_second_q   <= mf_end;
      sim_fbit_err   <= (mf_end || sim_second_q) &&
                        sim_code_q == SIM_FBIT;
      sim_mbit_err   <= (mf_end || sim_second_q) && !e1_mode &&
                        sim_code_q == SIM_MBIT;
      sim_parity_err <= mf_end && e1_mode &&
                        sim_code_q == SIM_MBIT;
    end
  end

  // zeros per multiframe; saturates since only "under five" matters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zero_cnt_q <= 3'h0;
      ais_cond_q <= 1'b0;
    end
    else if (ce)
    begin
      if (mf_end)
      begin
        ais_cond_q <= zero_cnt_q < AIS_ZERO_LIMIT ||
                      sim_code_q == SIM_AIS;
        zero_cnt_q <= 3'h0;
      end
      else if (rx_bit_valid && !rx_bit && zero_cnt_q < AIS_ZERO_LIMIT)
      begin
        zero_cnt_q <= zero_cnt_q + 3'h1;
      end
    end
  end

  // ais integrator: counts up while valid, flag declared at the limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ais_cnt_q <= 6'h00;
      ais_q     <= 1'b0;
    end
    else if (ce && alarm_tick)
    begin
      if (ais_cond_q)
      begin
        if (ais_cnt_q >= alarm_timer_params[5:0])
          ais_q <= 1'b1;
        else
          ais_cnt_q <= ais_cnt_q + 6'h01;
      end
      else if (ais_cnt_q == 6'h00)
      begin
        ais_q <= 1'b0;
      end
      else
      begin
        ais_cnt_q <= ais_cnt_q - 6'h01;
      end
    end
  end

  // red integrator; with no line signal there are no multiframes to
  // integrate, so red is forced at once while the framer is also out of frame
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      red_cnt_q <= 6'h00;
      red_q     <= 1'b0;
    end
    else if (ce)
    begin
      if (!signal_present && framer_oof)
      begin
        red_q <= 1'b1;
      end
      else if (alarm_tick)
      begin
        if (red_cond)
        begin
          if (red_cnt_q >= alarm_timer_params[5:0])
            red_q <= 1'b1;
          else
            red_cnt_q <= red_cnt_q + 6'h01;
        end
        else if (red_cnt_q == 6'h00)
        begin
          red_q <= 1'b0;
        end
        else
        begin
          red_cnt_q <= red_cnt_q - 6'h01;
        end
      end
    end
  end

  // spare bit exists only in the e1 format; reads zero otherwise
  ds2rx_persist #(
    .N_MF (FLAG_PERSIST)
  ) u_spare (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .step   (mf_end),
    .hold   (framer_oof),
    .in_bit (e1_mode && spare_bit),
    .flag   (spare_q)
  );

  ds2rx_persist #(
    .N_MF (FLAG_PERSIST)
  ) u_far (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .step   (mf_end),
    .hold   (framer_oof),
    .in_bit (far_src),
    .flag   (far_q)
  );

  // loop request: the selected c-bit disagrees with both others
  for (genvar t = 0; t < 4; t++)
  begin : g_trib
    logic [2:0] cb;
    logic       req;
    assign cb = rx_cbits[3*t +: 3];
    always_comb
    begin
      case (loop_cbit_select)
        CBIT_FIRST:  req = cb[0] != cb[1] && cb[0] != cb[2];
        CBIT_SECOND: req = cb[1] != cb[0] && cb[1] != cb[2];
        CBIT_THIRD:  req = cb[2] != cb[0] && cb[2] != cb[1];
        default:     req = 1'b0;
      endcase
    end
    ds2rx_persist #(
      .N_MF (LOOP_PERSIST)
    ) u_loop (
      .clk    (clk),
      .rst_n  (rst_n),
      .ce     (ce),
      .step   (mf_end),
      .hold   (1'b0),
      .in_bit (req || sim_code_q == SIM_LOOPCMD),
      .flag   (loop_q[t])
    );
  end

  // alignment moved is an event: held until software reads status,
  // and a new event in the read cycle wins over the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alignment_moved_flag_q <= 1'b0;
      oof_q  <= STATUS_RESET[0];
    end
    else if (ce)
    begin
      oof_q <= framer_oof;
      if (align_found && align_differs)
        alignment_moved_flag_q <= 1'b1;
      else if (reg_rd && reg_addr == ADDR_STATUS)
        alignment_moved_flag_q <= 1'b0;
    end
  end

  // vector sources follow the mask layout; alignment moved has no mask
  assign flags  = {ais_q, red_q, spare_q, far_q, alignment_moved_flag_q, oof_q};
  assign change = {|(loop_q ^ loop_prev_q),
                   flags[5:2] ^ flags_prev_q[5:2],
                   flags[0] ^ flags_prev_q[0]} & ~mask_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_prev_q   <= STATUS_RESET[5:0];
      loop_prev_q    <= LOOP_RESET[3:0];
      irq_vec_valid  <= 1'b0;
      irq_vec_source <= 6'h00;
      irq_vec_group  <= 3'h0;
    end
    else if (ce)
    begin
      flags_prev_q   <= flags;
      loop_prev_q    <= loop_q;
      irq_vec_valid  <= |change;
      irq_vec_source <= change;
      irq_vec_group  <= group_select;
    end
  end

  // read port answers one cycle later; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          ADDR_COMMAND: reg_rdata <= {9'h000, sim_code_q, 4'h0};
          ADDR_MASK:    reg_rdata <= {10'h000, mask_q};
          ADDR_STATUS:  reg_rdata <= status_word;
          ADDR_LOOP:    reg_rdata <= {12'h000, loop_q};
          default:      reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_copy;
    ce && cmd_wr && !counter_transfer_mode && reg_wdata[COPY_BIT] &&
    !reg_wdata[COPY_CLR_BIT] |=> cnt_copy && !cnt_clear;
  endproperty
  a_copy: assert property (p_copy)
    else $error("copy command did not copy alone");

  property p_copy_clear;
    ce && cmd_wr && !counter_transfer_mode && reg_wdata[COPY_CLR_BIT]
    |=> cnt_copy && cnt_clear;
  endproperty
  a_copy_clear: assert property (p_copy_clear)
    else $error("copy and clear command missing");

  property p_self_clear;
    cnt_copy && ce && !copy_req |=> !cnt_copy;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("counter command did not self clear");

  property p_masked;
    irq_vec_valid |-> (irq_vec_source & $past(mask_q)) == 6'h00;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked source produced a vector");

  property p_oof;
    ce |=> status_word[0] == $past(framer_oof);
  endproperty
  a_oof: assert property (p_oof)
    else $error("out of frame bit does not follow framer");

  property p_alignment_moved_flag;
    ce && align_found && align_differs |=> alignment_moved_flag_q ##0 status_word[1];
  endproperty
  a_alignment_moved_flag: assert property (p_alignment_moved_flag)
    else $error("alignment moved flag not set");

  property p_fbit;
    ce && mf_end && sim_code_q == SIM_FBIT |=> sim_fbit_err;
  endproperty
  a_fbit: assert property (p_fbit)
    else $error("simulated framing error missing");

  property p_red_nosig;
    ce && !signal_present && framer_oof |=> red_q && status_word[4];
  endproperty
  a_red_nosig: assert property (p_red_nosig)
    else $error("red flag not set without signal");

  property p_ais_valid;
    ce && mf_end |=>
      ais_cond_q == ($past(zero_cnt_q) < AIS_ZERO_LIMIT ||
                     $past(sim_code_q) == SIM_AIS);
  endproperty
  a_ais_valid: assert property (p_ais_valid)
    else $error("ais multiframe decision wrong");

endmodule : ds2rx_status_ctrl
`default_nettype wire

// ==== rtl/ds2rx_pkg.sv ====
`default_nettype none
package ds2rx_pkg;

  // register map, byte addresses
  localparam logic [11:0] ADDR_COMMAND = 12'h228;
  localparam logic [11:0] ADDR_MASK    = 12'h22c;
  localparam logic [11:0] ADDR_STATUS  = 12'h230;
  localparam logic [11:0] ADDR_LOOP    = 12'h234;

  // values after reset
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET    = 16'h003f;
  localparam logic [15:0] STATUS_RESET  = 16'h0001;
  localparam logic [15:0] LOOP_RESET    = 16'h0000;

  // command register fields
  localparam int SIM_LSB      = 4;
  localparam int SIM_MSB      = 6;
  localparam int COPY_BIT     = 1;
  localparam int COPY_CLR_BIT = 0;

  // error simulation codes
  localparam logic [2:0] SIM_NONE    = 3'h0;
  localparam logic [2:0] SIM_FBIT    = 3'h1;
  localparam logic [2:0] SIM_MBIT    = 3'h2;
  localparam logic [2:0] SIM_FAR     = 3'h3;
  localparam logic [2:0] SIM_RED     = 3'h4;
  localparam logic [2:0] SIM_AIS     = 3'h5;
  localparam logic [2:0] SIM_LOOPCMD = 3'h6;

  // mask bit positions
  localparam int MSK_LOOP  = 5;
  localparam int MSK_AIS   = 4;
  localparam int MSK_RED   = 3;
  localparam int MSK_SPARE = 2;
  localparam int MSK_FAR   = 1;
  localparam int MSK_FAS   = 0;

  // loopback c-bit selector codes
  localparam logic [1:0] CBIT_FIRST  = 2'h0;
  localparam logic [1:0] CBIT_SECOND = 2'h1;
  localparam logic [1:0] CBIT_THIRD  = 2'h2;

  // zeros limit per multiframe and multiframe counts
  localparam logic [2:0] AIS_ZERO_LIMIT = 3'h5;
  localparam logic [3:0] FLAG_PERSIST   = 4'h8;
  localparam logic [3:0] LOOP_PERSIST   = 4'h5;

  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int HALF_MS_NS      = 500000;
  localparam int ONE_SEC_NS      = 1000000000;
  localparam int HALF_MS_CYCLES  = HALF_MS_NS / CLK_PERIOD_NS;
  localparam int ONE_SEC_CYCLES  = ONE_SEC_NS / CLK_PERIOD_NS;

endpackage : ds2rx_pkg
`default_nettype wire

// ==== rtl/ds2rx_persist.sv ====
`timescale 1ns/1ps
`default_nettype none
// a new input value is taken only after it held for n_mf multiframe steps
module ds2rx_persist
  import ds2rx_pkg::*;
#(
  parameter logic [3:0] N_MF = FLAG_PERSIST
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic step,
  input  wire logic hold,
  input  wire logic in_bit,
  output var  logic flag
);

  logic [3:0] run_q;

  // hold freezes both count and flag so an unaligned framer keeps reporting the last flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= 4'h0;
      flag  <= 1'b0;
    end
    else if (ce && step && !hold)
    begin
      if (in_bit == flag)
      begin
        run_q <= 4'h0;
      end
      else if (run_q == N_MF - 4'h1)
      begin
        flag  <= in_bit;
        run_q <= 4'h0;
      end
      else
      begin
        run_q <= run_q + 4'h1;
      end
    end
  end

endmodule : ds2rx_persist
`default_nettype wire

// ==== test/ds2rx_demux_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// demultiplexer stand-in: multiframe ticks and a received bit stream
module ds2rx_demux_model #(
  parameter int MF_CYC = 20
)
(
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [4:0] zeros,
  output var  logic       mf_end = 1'b0,
  output var  logic       bit_valid = 1'b0,
  output var  logic       bit_val = 1'b0
);
  int pos = 0;

  // zeros lead each multiframe so the count per frame is exact;
  // when stopped the data line toggles instead of holding a stale bit
  always @(negedge clk)
  begin
    mf_end    <= run && pos == MF_CYC - 1;
    bit_valid <= run;
    bit_val   <= run ? pos >= zeros : ~bit_val;
    pos       <= (run && pos < MF_CYC - 1) ? pos + 1 : 0;
  end
endmodule : ds2rx_demux_model
`default_nettype wire

// ==== test/ds2rx_status_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module ds2rx_status_ctrl_bench;
  import ds2rx_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce_i = 1'b1;
  logic [11:0] addr = 12'h000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        rvalid;
  logic [2:0]  grp = 3'h0;
  logic        auto_m = 1'b0;
  logic        e1 = 1'b0;
  logic [1:0]  csel = 2'h3;
  logic        sig = 1'b1;
  logic        oof = 1'b1;
  logic        af = 1'b0;
  logic        ad = 1'b0;
  logic        spare = 1'b0;
  logic        fare = 1'b0;
  logic [11:0] cbits = 12'h000;
  logic        run = 1'b0;
  logic [4:0]  zeros = 5'h0a;
  logic        mf_end;
  logic        bval;
  logic        bdat;
  logic        cc;
  logic        cl;
  logic        fe;
  logic        me;
  logic        pe;
  logic        iv;
  logic [5:0]  isrc;
  logic [2:0]  igrp;
  logic [5:0]  src_or = 6'h00;
  logic [2:0]  last_grp = 3'h0;
  int          fail_count = 0;
  int          tests_run = 0;
  int          n_cc = 0;
  int          n_cl = 0;
  int          n_f = 0;
  int          n_m = 0;
  int          n_p = 0;

  ds2rx_status_ctrl #(.HALF_MS_CYC(20), .ONE_SEC_CYC(50)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce_i), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .group_select(grp),
    .counter_transfer_mode(auto_m), .e1_mode(e1),
    .loop_cbit_select(csel), .alarm_timer_params(8'h03),
    .mf_end(mf_end), .rx_bit_valid(bval), .rx_bit(bdat),
    .signal_present(sig), .framer_oof(oof), .align_found(af),
    .align_differs(ad), .spare_bit(spare), .far_bit_ds1(1'b0),
    .far_bit_e1(fare), .rx_cbits(cbits), .cnt_copy(cc),
    .cnt_clear(cl), .sim_fbit_err(fe), .sim_mbit_err(me),
    .sim_parity_err(pe), .irq_vec_valid(iv), .irq_vec_source(isrc),
    .irq_vec_group(igrp)
  );

  ds2rx_demux_model #(.MF_CYC(20)) far_end (
    .clk(clk), .run(run), .zeros(zeros), .mf_end(mf_end),
    .bit_valid(bval), .bit_val(bdat)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  // pulse counters; scenarios zero them at the start of a window
  always @(posedge clk)
  begin
    n_cc += cc;
    n_cl += cl;
    n_f += fe;
    n_m += me;
    n_p += pe;
    if (iv === 1'b1)
    begin
      src_or |= isrc;
      last_grp = igrp;
    end
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr16(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr16

  // read answer comes exactly one edge after the strobe is taken and
  // rvalid stands for that one cycle only, so look at it right away
  task automatic rd16(input logic [11:0] a, input logic [15:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({15'h0, rvalid}, 16'h0001);
    chk(rdata, exp);
  endtask : rd16

  // bounded wait for n multiframe ends
  task automatic mfs(input int n);
    int k;
    k = 0;
    while (n > 0)
    begin
      @(negedge clk);
      k++;
      if (mf_end === 1'b1)
        n--;
      if (k > 4000)
      begin
        fail_count++;
        print_verdict();
      end
    end
  endtask : mfs

  task automatic t_regs;
    rd16(ADDR_STATUS, STATUS_RESET);
    rd16(ADDR_MASK, MASK_RESET);
    rd16(ADDR_COMMAND, COMMAND_RESET);
    rd16(ADDR_LOOP, LOOP_RESET);
    rd16(12'h238, 16'h0000);
    sig = 1'b0;
    repeat (3) @(negedge clk);
    rd16(ADDR_STATUS, 16'h0011);
    wr16(ADDR_STATUS, 16'hffff);
    wr16(ADDR_LOOP, 16'hffff);
    rd16(ADDR_STATUS, 16'h0011);
    rd16(ADDR_LOOP, 16'h0000);
    // a write while the clock enable is low must not land
    ce_i = 1'b0;
    wr16(ADDR_MASK, 16'h0000);
    ce_i = 1'b1;
    rd16(ADDR_MASK, MASK_RESET);
    wr16(ADDR_MASK, 16'h0000);
    rd16(ADDR_MASK, 16'h0000);
  endtask : t_regs

  task automatic t_counters;
    wr16(ADDR_COMMAND, 16'h0001);
    chk({14'h0, cc, cl}, 16'h0003);
    @(negedge clk);
    chk({14'h0, cc, cl}, 16'h0000);
    wr16(ADDR_COMMAND, 16'h0002);
    chk({14'h0, cc, cl}, 16'h0002);
    rd16(ADDR_COMMAND, 16'h0000);
    auto_m = 1'b1;
    n_cc = 0;
    n_cl = 0;
    wr16(ADDR_COMMAND, 16'h0002);
    repeat (120) @(negedge clk);
    chk(16'(n_cc), 16'(n_cl));
    chk({15'h0, n_cl > 1}, 16'h0001);
    auto_m = 1'b0;
  endtask : t_counters

  // counts are taken away from the multiframe boundaries
  task automatic t_sim(input logic [2:0] code, input logic e1m,
                       input logic [15:0] exp);
    e1 = e1m;
    wr16(ADDR_COMMAND, {9'h0, code, 4'h0});
    mfs(1);
    repeat (5) @(negedge clk);
    n_f = 0;
    n_m = 0;
    n_p = 0;
    mfs(2);
    repeat (5) @(negedge clk);
    chk({4'h0, 4'(n_f), 4'(n_m), 4'(n_p)}, exp);
    wr16(ADDR_COMMAND, 16'h0000);
  endtask : t_sim

  task automatic t_vector;
    sig = 1'b1;
    grp = 3'h5;
    src_or = 6'h00;
    oof = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, src_or[0], 5'h0, last_grp}, 16'h0105);
    wr16(ADDR_MASK, 16'h0001);
    src_or = 6'h00;
    oof = 1'b1;
    repeat (4) @(negedge clk);
    chk({15'h0, src_or[0]}, 16'h0000);
    oof = 1'b0;
    wr16(ADDR_MASK, MASK_RESET);
  endtask : t_vector

  task automatic t_alarms;
    logic [2:0]  sc [4] = '{SIM_RED, SIM_AIS, SIM_FAR, SIM_NONE};
    logic [15:0] se [4] = '{16'h0010, 16'h0020, 16'h0004, 16'h0000};
    mfs(6);
    rd16(ADDR_STATUS, 16'h0000);
    zeros = 5'h04;
    mfs(6);
    rd16(ADDR_STATUS, 16'h0020);
    zeros = 5'h05;
    mfs(6);
    rd16(ADDR_STATUS, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr16(ADDR_COMMAND, {9'h0, sc[i], 4'h0});
      mfs(10);
      rd16(ADDR_STATUS, se[i]);
    end
  endtask : t_alarms

  task automatic t_persist;
    e1 = 1'b1;
    spare = 1'b1;
    fare = 1'b1;
    mfs(6);
    rd16(ADDR_STATUS, 16'h0000);
    mfs(4);
    rd16(ADDR_STATUS, 16'h000c);
    oof = 1'b1;
    spare = 1'b0;
    fare = 1'b0;
    mfs(10);
    rd16(ADDR_STATUS, 16'h001d);
    oof = 1'b0;
    mfs(10);
    rd16(ADDR_STATUS, 16'h0000);
    e1 = 1'b0;
  endtask : t_persist

  // a new alignment at the expected place must not flag a move
  task automatic t_alignment_moved_flag;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk);
      af = 1'b1;
      ad = i[0];
      @(negedge clk);
      af = 1'b0;
      rd16(ADDR_STATUS, {14'h0, i[0], 1'b0});
    end
    rd16(ADDR_STATUS, 16'h0000);
  endtask : t_alignment_moved_flag

  task automatic t_loop;
    logic [15:0] prev;
    prev = 16'h0000;
    for (int s = 0; s < 3; s++)
    begin
      csel = 2'(s);
      cbits = 12'h001 << (4 * s);
      mfs(3);
      rd16(ADDR_LOOP, prev);
      mfs(4);
      prev = 16'h0001 << s;
      rd16(ADDR_LOOP, prev);
    end
    cbits = 12'h000;
    wr16(ADDR_COMMAND, {9'h0, SIM_LOOPCMD, 4'h0});
    mfs(7);
    rd16(ADDR_LOOP, 16'h000f);
    wr16(ADDR_COMMAND, 16'h0000);
    mfs(7);
    rd16(ADDR_LOOP, 16'h0000);
  endtask : t_loop

  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_counters();
    run = 1'b1;
    t_sim(SIM_FBIT, 1'b0, 16'h0400);
    t_sim(SIM_MBIT, 1'b0, 16'h0040);
    t_sim(SIM_MBIT, 1'b1, 16'h0002);
    t_sim(SIM_NONE, 1'b0, 16'h0000);
    t_vector();
    t_alarms();
    t_persist();
    t_alignment_moved_flag();
    t_loop();
    print_verdict();
  end
endmodule : ds2rx_status_ctrl_bench
`default_nettype wire
